// File: rtl/cbs_pkg.sv
// constants and types of the bus cycle sequencer
// Function
// - read cycles drive rw high, write cycles low, steady for the cycle
// - same mode and cycle count give the same per-cycle bus sequence
// - internal read values reach the external bus only in mode 0
// - immediate: 8-bit ops two cycles, 16-bit loads three, high byte first
// - 16-bit compare/add/subtract end with an ignored read at FFFF
// - direct reads: 8-bit three cycles, 16-bit loads four, high then low
// - direct stores: 8-bit writes in cycle 3, 16-bit writes high then low
// - direct call: opcode, address byte, target opcode, push low, push high
// - 16-bit values put the high byte at the lower address
package cbs_pkg;

  // ----------------------------------------------------------------------
  // bus cycle timing
  // ----------------------------------------------------------------------
  localparam logic [1:0]  PH_LAST    = 2'h3;
  localparam logic [1:0]  PH_FIRST   = 2'h0;
  localparam logic [1:0]  PH_ONE     = 2'h1;
  localparam int          SYNC_W     = 9;

  // ----------------------------------------------------------------------
  // bus values
  // ----------------------------------------------------------------------
  localparam logic        RW_READ    = 1'b1;
  localparam logic        RW_WRITE   = 1'b0;
  localparam logic [15:0] ADDR_DEAD  = 16'hFFFF;
  localparam logic [7:0]  DIR_PAGE   = 8'h00;
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [15:0] OFS_ONE    = 16'h0001;
  localparam logic [15:0] OFS_TWO    = 16'h0002;
  localparam logic [15:0] OFS_THREE  = 16'h0003;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;

  // ----------------------------------------------------------------------
  // instruction classes from the opcode decoder
  // ----------------------------------------------------------------------
  localparam logic [3:0]  CLS_ALU8_IMM = 4'h0;
  localparam logic [3:0]  CLS_LD16_IMM = 4'h1;
  localparam logic [3:0]  CLS_AR16_IMM = 4'h2;
  localparam logic [3:0]  CLS_ALU8_DIR = 4'h3;
  localparam logic [3:0]  CLS_ST8_DIR  = 4'h4;
  localparam logic [3:0]  CLS_LD16_DIR = 4'h5;
  localparam logic [3:0]  CLS_ST16_DIR = 4'h6;
  localparam logic [3:0]  CLS_AR16_DIR = 4'h7;
  localparam logic [3:0]  CLS_CALL_DIR = 4'h8;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_FETCH = 5'h01,
    ST_OPND  = 5'h02,
    ST_C3    = 5'h04,
    ST_C4    = 5'h08,
    ST_C5    = 5'h10
  } cbs_state_t;

endpackage : cbs_pkg

// File: rtl/cbs_sync.sv
// two flip-flop synchroniser for the data pins and the mode strap
module cbs_sync (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic [cbs_pkg::SYNC_W-1:0] async_in,
  output logic      [cbs_pkg::SYNC_W-1:0] sync_out
);
  import cbs_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } cbs_sync_t;

  cbs_sync_t s_reg;
  cbs_sync_t s_next;

  always_comb begin
    s_next        = s_reg;
    s_next.meta   = async_in;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stable;

endmodule : cbs_sync

// File: rtl/cbs_sequencer.sv
// per-cycle external bus sequencer for immediate and direct instructions
module cbs_sequencer (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  bus_data_in,
  input  wire logic        mode_zero,
  input  wire logic        internal_sel,
  input  wire logic [7:0]  internal_data,
  input  wire logic [3:0]  op_class,
  input  wire logic [7:0]  acc_data,
  input  wire logic [15:0] store_word,
  input  wire logic [15:0] stack_ptr,
  output logic      [15:0] bus_addr,
  output logic             bus_rw,
  output logic      [7:0]  bus_data_out,
  output logic             bus_data_oe,
  output logic      [7:0]  opcode,
  output logic      [15:0] operand_word,
  output logic             instr_done
);
  import cbs_pkg::*;

  typedef struct packed {
    cbs_state_t  st;
    logic [1:0]  phase;
    logic [15:0] pc;
    logic [3:0]  cls;
    logic [15:0] addr;
    logic        rw;
    logic [7:0]  dout;
    logic        doe;
    logic [7:0]  opc;
    logic [15:0] opnd;
    logic        done;
  } cbs_seq_t;

  cbs_seq_t          s_reg;
  cbs_seq_t          s_next;
  logic [SYNC_W-1:0] pins_sync;
  logic [7:0]        din;
  logic              mode0;

  // ----------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------
  cbs_sync u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .async_in ({mode_zero, bus_data_in}),
    .sync_out (pins_sync)
  );

  assign din   = pins_sync[7:0];
  assign mode0 = pins_sync[SYNC_W-1];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0] nb_addr;
    logic        nb_rw;
    logic [7:0]  nb_wd;
    logic        fin;
    logic [15:0] fin_pc;
    logic [15:0] ea;
    logic [15:0] ret;
    nb_addr = s_reg.addr;
    nb_rw   = RW_READ;
    nb_wd   = BYTE_ZERO;
    fin     = 1'b0;
    fin_pc  = s_reg.pc;
    ea      = {DIR_PAGE, s_reg.opnd[7:0]};
    ret     = s_reg.pc + OFS_TWO;
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (s_reg.rw == RW_READ) begin
      s_next.doe  = mode0 & internal_sel;
      s_next.dout = internal_data;
    end
    if (s_reg.phase == PH_LAST) begin
      s_next.phase = PH_FIRST;
      case (s_reg.st)
        ST_FETCH: begin
          s_next.opc = din;
          s_next.st  = ST_OPND;
          nb_addr    = s_reg.pc + OFS_ONE;
        end
        ST_OPND: begin
          s_next.cls  = op_class;
          s_next.opnd = {BYTE_ZERO, din};
          s_next.st   = ST_C3;
          nb_addr     = {DIR_PAGE, din};
          case (op_class)
            CLS_ALU8_IMM: begin
              fin    = 1'b1;
              fin_pc = s_reg.pc + OFS_TWO;
            end
            CLS_LD16_IMM, CLS_AR16_IMM: begin
              s_next.opnd = {din, BYTE_ZERO};
              nb_addr     = s_reg.pc + OFS_TWO;
            end
            CLS_ALU8_DIR, CLS_LD16_DIR, CLS_AR16_DIR, CLS_CALL_DIR: begin
              nb_rw = RW_READ;
            end
            CLS_ST8_DIR: begin
              nb_rw = RW_WRITE;
              nb_wd = acc_data;
            end
            CLS_ST16_DIR: begin
              nb_rw = RW_WRITE;
              nb_wd = store_word[15:8];
            end
            default: begin
              fin    = 1'b1;
              fin_pc = s_reg.pc + OFS_ONE;
            end
          endcase
        end
        ST_C3: begin
          s_next.st = ST_C4;
          case (s_reg.cls)
            CLS_LD16_IMM: begin
              s_next.opnd[7:0] = din;
              fin              = 1'b1;
              fin_pc           = s_reg.pc + OFS_THREE;
            end
            CLS_AR16_IMM: begin
              s_next.opnd[7:0] = din;
              nb_addr          = ADDR_DEAD;
            end
            CLS_ALU8_DIR: begin
              s_next.opnd = {BYTE_ZERO, din};
              fin         = 1'b1;
              fin_pc      = s_reg.pc + OFS_TWO;
            end
            CLS_LD16_DIR, CLS_AR16_DIR: begin
              s_next.opnd = {din, s_reg.opnd[7:0]};
              nb_addr     = ea + OFS_ONE;
            end
            CLS_ST16_DIR: begin
              nb_addr = ea + OFS_ONE;
              nb_rw   = RW_WRITE;
              nb_wd   = store_word[7:0];
            end
            CLS_CALL_DIR: begin
              s_next.opc  = din;
              s_next.opnd = ea;
              nb_addr     = stack_ptr;
              nb_rw       = RW_WRITE;
              nb_wd       = ret[7:0];
            end
            default: begin
              fin    = 1'b1;
              fin_pc = s_reg.pc + OFS_TWO;
            end
          endcase
        end
        ST_C4: begin
          s_next.st = ST_C5;
          case (s_reg.cls)
            CLS_AR16_IMM: begin
              fin    = 1'b1;
              fin_pc = s_reg.pc + OFS_THREE;
            end
            CLS_LD16_DIR: begin
              s_next.opnd[7:0] = din;
              fin              = 1'b1;
              fin_pc           = s_reg.pc + OFS_TWO;
            end
            CLS_AR16_DIR: begin
              s_next.opnd[7:0] = din;
              nb_addr          = ADDR_DEAD;
            end
            CLS_CALL_DIR: begin
              nb_addr = stack_ptr - OFS_ONE;
              nb_rw   = RW_WRITE;
              nb_wd   = ret[15:8];
            end
            default: begin
              fin    = 1'b1;
              fin_pc = s_reg.pc + OFS_TWO;
            end
          endcase
        end
        ST_C5: begin
          if (s_reg.cls == CLS_CALL_DIR) begin
            s_next.pc   = s_reg.opnd;
            s_next.st   = ST_OPND;
            s_next.done = 1'b1;
            nb_addr     = s_reg.opnd + OFS_ONE;
          end else begin
            fin    = 1'b1;
            fin_pc = s_reg.pc + OFS_TWO;
          end
        end
        default: begin
          fin    = 1'b1;
          fin_pc = s_reg.pc;
        end
      endcase
      if (fin) begin
        s_next.pc   = fin_pc;
        s_next.st   = ST_FETCH;
        s_next.done = 1'b1;
        nb_addr     = fin_pc;
      end
      s_next.addr = nb_addr;
      s_next.rw   = nb_rw;
      s_next.dout = nb_wd;
      s_next.doe  = (nb_rw == RW_WRITE);
    end else begin
      s_next.phase = s_reg.phase + PH_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg       <= '0;
      s_reg.st    <= ST_FETCH;
      s_reg.pc    <= PC_RESET;
      s_reg.addr  <= PC_RESET;
      s_reg.rw    <= RW_READ;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign bus_addr     = s_reg.addr;
  assign bus_rw       = s_reg.rw;
  assign bus_data_out = s_reg.dout;
  assign bus_data_oe  = s_reg.doe;
  assign opcode       = s_reg.opc;
  assign operand_word = s_reg.opnd;
  assign instr_done   = s_reg.done;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence seq_cycle_end;
    ce && (s_reg.phase == PH_LAST);
  endsequence

  sequence seq_mid_cycle;
    ce && (s_reg.phase != PH_LAST);
  endsequence

  chk_rw_steady: assert property (seq_mid_cycle
      |=> $stable(bus_rw) && $stable(bus_addr))
    else $error("rw or address changed inside a bus cycle");

  chk_write_drive: assert property ((bus_rw == RW_WRITE) |-> bus_data_oe)
    else $error("write cycle without data drive");

  chk_internal_echo: assert property ((bus_data_oe && bus_rw == RW_READ) |-> mode0)
    else $error("internal read driven outside mode 0");

  chk_imm_short: assert property ((seq_cycle_end and s_reg.st == ST_OPND
      && op_class == CLS_ALU8_IMM) |=> instr_done && bus_addr == $past(s_reg.pc) + OFS_TWO)
    else $error("immediate 8-bit op not two cycles");

  chk_dead_read: assert property ((seq_cycle_end and s_reg.st == ST_C3
      && s_reg.cls == CLS_AR16_IMM) |=> bus_addr == ADDR_DEAD && bus_rw == RW_READ)
    else $error("missing dead read at FFFF");

  chk_direct_page: assert property ((s_reg.st == ST_C3 && (s_reg.cls == CLS_ALU8_DIR
      || s_reg.cls == CLS_ST8_DIR || s_reg.cls == CLS_LD16_DIR))
      |-> bus_addr[15:8] == DIR_PAGE)
    else $error("direct address upper byte not zero");

  chk_store_order: assert property ((seq_cycle_end and s_reg.st == ST_C3
      && s_reg.cls == CLS_ST16_DIR) |=> bus_addr == $past(bus_addr) + OFS_ONE
      && bus_rw == RW_WRITE)
    else $error("16-bit store low byte not at next address");

  chk_call_push: assert property ((seq_cycle_end and s_reg.st == ST_C4
      && s_reg.cls == CLS_CALL_DIR) |=> bus_rw == RW_WRITE
      && bus_addr == $past(stack_ptr) - OFS_ONE)
    else $error("call high push not at stack minus one");

  chk_next_fetch: assert property (instr_done
      |-> (s_reg.st == ST_FETCH && bus_addr == s_reg.pc)
      || (s_reg.st == ST_OPND && bus_addr == s_reg.pc + OFS_ONE))
    else $error("next fetch address wrong after instruction");

endmodule : cbs_sequencer

// File: testbench/cbs_mem_model.sv
// external memory model on the far side of the bus
module cbs_mem_model (
  input  wire logic        mclk,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rw,
  output wire logic [7:0]  bus_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  bit   [7:0] mem [0:65535];
  logic [7:0] last_reg;
  // released pins show the inverse of the last byte
  always_ff @(posedge mclk) begin
    if (bus_rw) begin
      last_reg <= bus_data_in;
    end
  end
  assign bus_data_in = bus_rw ? mem[bus_addr] : ~last_reg;
endmodule : cbs_mem_model

// File: testbench/tb_cbs_sequencer.sv
// self-checking bench of the bus cycle sequencer
module tb_cbs_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import cbs_pkg::*;
  typedef struct packed {logic [15:0] a; logic rw; logic [7:0] d;} cbs_cyc_t;
  typedef struct packed {logic v; logic [7:0] op; logic [15:0] w;} cbs_opw_t;
  localparam logic [67:0] PROG = 68'h01234567802764531;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        mode_zero = 1'b0;
  logic        mz_prev = 1'b0;
  logic        ce = 1'b1;
  logic        adv = 1'b0;
  logic [31:0] ce_pat = 32'hFFFFFFFF;
  logic        internal_sel, bus_rw, bus_data_oe, instr_done;
  logic [7:0]  bus_data_in, internal_data, acc_data, bus_data_out, opcode, b1, b2;
  logic [3:0]  op_class;
  logic [15:0] store_word, stack_ptr, bus_addr, operand_word, pc, aa;
  cbs_cyc_t    exp_q[$];
  cbs_opw_t    opw_q[$];
  cbs_cyc_t    mc;
  cbs_opw_t    o, mo;
  bit          skip;
  int          n = -1;
  int          tick = 0;
  int          n_errors = 0;
  int          n_checks = 0;

  always #2.5 mclk = ~mclk;
  assign internal_sel  = bus_addr < 16'h0080;
  assign internal_data = bus_addr[7:0] ^ 8'hA5;
  assign op_class      = (opcode[7:4] == 4'hC) ? opcode[3:0] : 4'hF;

  cbs_sequencer i_cbs_sequencer (
    .mclk(mclk), .rst(rst), .ce(ce), .bus_data_in(bus_data_in), .mode_zero(mode_zero),
    .internal_sel(internal_sel), .internal_data(internal_data), .op_class(op_class),
    .acc_data(acc_data), .store_word(store_word), .stack_ptr(stack_ptr),
    .bus_addr(bus_addr), .bus_rw(bus_rw), .bus_data_out(bus_data_out),
    .bus_data_oe(bus_data_oe), .opcode(opcode), .operand_word(operand_word),
    .instr_done(instr_done)
  );
  cbs_mem_model i_cbs_mem_model (
    .mclk(mclk), .bus_addr(bus_addr), .bus_rw(bus_rw), .bus_data_in(bus_data_in)
  );

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic emit(logic [15:0] a, logic rw, logic [7:0] d);
    exp_q.push_back({a, rw, d});
  endtask : emit

  task automatic put(logic [15:0] a, logic [7:0] d);
    i_cbs_mem_model.mem[a] = d;
  endtask : put

  // lays one instruction into memory and notes its bus cycles
  task automatic ins(logic [3:0] cls, int idx);
    put(pc, {4'hC, cls});
    if (!skip) begin
      emit(pc, RW_READ, BYTE_ZERO);
    end else begin
      o = opw_q.pop_back();
      o.op = {4'hC, cls};
      opw_q.push_back(o);
    end
    skip = 0;
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    aa = {DIR_PAGE, 8'hC0 + 8'(2 * idx)};
    if (cls == CLS_CALL_DIR) begin
      aa = 16'h0060;
    end
    o = {1'b1, 4'hC, cls, BYTE_ZERO, b1};
    put(pc + OFS_ONE, (cls <= CLS_AR16_IMM) ? b1 : aa[7:0]);
    emit(pc + OFS_ONE, RW_READ, BYTE_ZERO);
    if (cls <= CLS_AR16_IMM) begin
      if (cls != CLS_ALU8_IMM) begin
        put(pc + OFS_TWO, b2);
        emit(pc + OFS_TWO, RW_READ, BYTE_ZERO);
        o.w = {b1, b2};
      end
      pc = pc + ((cls == CLS_ALU8_IMM) ? OFS_TWO : OFS_THREE);
    end else begin
      pc = pc + OFS_TWO;
      put(aa, b1);
      put(aa + OFS_ONE, b2);
      case (cls)
        CLS_ALU8_DIR: emit(aa, RW_READ, BYTE_ZERO);
        CLS_ST8_DIR: begin
          emit(aa, RW_WRITE, acc_data);
          o.v = 1'b0;
        end
        CLS_ST16_DIR: begin
          emit(aa, RW_WRITE, store_word[15:8]);
          emit(aa + OFS_ONE, RW_WRITE, store_word[7:0]);
          o.v = 1'b0;
        end
        CLS_CALL_DIR: begin
          emit(aa, RW_READ, BYTE_ZERO);
          emit(stack_ptr, RW_WRITE, pc[7:0]);
          emit(stack_ptr - OFS_ONE, RW_WRITE, pc[15:8]);
          o.w = aa;
          pc = aa;
          skip = 1;
        end
        default: begin
          emit(aa, RW_READ, BYTE_ZERO);
          emit(aa + OFS_ONE, RW_READ, BYTE_ZERO);
          o.w = {b1, b2};
        end
      endcase
    end
    if (cls == CLS_AR16_IMM || cls == CLS_AR16_DIR) begin
      emit(ADDR_DEAD, RW_READ, BYTE_ZERO);
    end
    opw_q.push_back(o);
  endtask : ins

  // ----------------------------------------------------------------------
  // cycle count, timeout and output monitor
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    n <= rst ? -1 : n + int'(ce);
    adv <= ce && !rst;
    tick <= tick + 1;
    if (tick > 2000) begin
      n_errors++;
      wrap_up();
    end
  end

  // clock enable pattern, drawn once from the seeded generator
  always @(negedge mclk) begin
    ce <= ce_pat[tick[4:0]];
  end

  always @(negedge mclk) begin
    if (!rst && adv && instr_done === 1'b1 && opw_q.size() > 0) begin
      mo = opw_q.pop_front();
      check("opcode", 16'(opcode), 16'(mo.op));
      if (mo.v) check("operand", operand_word, mo.w);
    end
    if (!rst && adv && n % 4 == 1 && exp_q.size() > 0) begin
      mc = exp_q.pop_front();
      check("address", bus_addr, mc.a);
      check("rw", 16'(bus_rw), 16'(mc.rw));
      if (mc.rw == RW_WRITE) begin
        check("write oe", 16'(bus_data_oe), 16'h0001);
        check("write data", 16'(bus_data_out), 16'(mc.d));
      end else if (mode_zero == mz_prev) begin
        check("read oe", 16'(bus_data_oe), 16'(mode_zero & internal_sel));
        if (mode_zero & internal_sel) begin
          check("read data", 16'(bus_data_out), 16'(internal_data));
        end
      end
      mz_prev = mode_zero;
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h54DC47A2));
    ce_pat = $urandom | 32'hFFFF0000;
    acc_data = 8'($urandom);
    store_word = 16'($urandom);
    stack_ptr = 16'($urandom);
    pc = PC_RESET;
    skip = 0;
    for (int i = 0; i < 17; i++) begin
      ins(PROG[67 - 4 * i -: 4], i);
    end
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    while (exp_q.size() > 30) @(negedge mclk);
    mode_zero = 1'b1;
    $display("test normal mode done");
    while (exp_q.size() > 0 || opw_q.size() > 0) @(negedge mclk);
    $display("test mode zero done");
    wrap_up();
  end
endmodule : tb_cbs_sequencer
